// ### rtl/serial_irq_host.sv
// Host controller end of the serial interrupt link
`timescale 1ns/100ps
`default_nettype none
module serial_irq_host
	import serial_irq_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic quiet_req,
	input wire logic continuous_run,
	input wire logic [2:0] start_ext,
	input wire logic eoi_req,
	output logic [15:1] irq_state,
	output logic update_pulse,
	output logic eoi_grant,
	serial_irq_if.host link
);
	host_state_t state;
	host_state_t next_state;
	logic [4:0] cfg_meta;
	logic [4:0] cfg_sync;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [2:0] len;
	logic [2:0] next_len;
	logic mode_quiet;
	logic first_pending;
	logic oe_q;
	logic out_q;
	logic [16:0] cap;
	logic [15:1] pub;
	logic pub_tgl;
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;
	logic [6:0] eoi_cnt;
	logic eoi_busy;

	wire line = link.serial_int_line;
	wire cfg_quiet = cfg_sync[4];
	wire cfg_cont = cfg_sync[3];
	wire [2:0] cfg_ext = cfg_sync[2:0];
	wire [2:0] ext = (cfg_ext < START_EXT_MIN) ? START_EXT_MIN : cfg_ext;
	wire want = first_pending || cfg_cont;
	wire kick_seen = (state == H_IDLE) && !line && mode_quiet;
	wire [2:0] stop_len = cfg_quiet ? 3'(STOP_QUIET_W - 2'h1) : 3'(STOP_CONT_W - 2'h1);
	wire [7:0] cur_frame = sample_frame(cnt);
	wire cap_now = (state == H_FRAMES) && is_sample(cnt) && (cur_frame >= FIRST_DEV_FRAME)
		&& (cur_frame <= LAST_DEV_FRAME);
	wire stop_begin = (state == H_FRAMES) && (cnt == HOST_LAST_TA);
	wire next_oe = (next_state == H_START_LOW) || (next_state == H_START_HIGH)
		|| (next_state == H_STOP_LOW) || (next_state == H_STOP_HIGH);
	wire next_out = (next_state == H_START_HIGH) || (next_state == H_STOP_HIGH);

	// Line released while bus reset is held
	assign link.host_oe = oe_q && !link.bus_reset_in;
	assign link.host_out = out_q;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_len = len;
		case (state)
			H_IDLE:
				if (kick_seen)
				begin
					next_state = H_START_LOW;
					next_len = ext - 3'h1;
				end
				else if (want)
				begin
					next_state = H_START_LOW;
					next_len = ext;
				end
			H_START_LOW:
				if (len == 3'h0)
					next_state = H_START_HIGH;
				else
					next_len = len - 3'h1;
			H_START_HIGH:
			begin
				next_state = H_FRAMES;
				next_cnt = 8'h01;
			end
			H_FRAMES:
				if (stop_begin)
				begin
					next_state = H_STOP_LOW;
					next_len = stop_len;
				end
				else
					next_cnt = cnt + 8'h01;
			H_STOP_LOW:
				if (len == 3'h0)
					next_state = H_STOP_HIGH;
				else
					next_len = len - 3'h1;
			H_STOP_HIGH:
				next_state = H_STOP_TA;
			H_STOP_TA:
				if (want)
				begin
					next_state = H_START_LOW;
					next_len = ext;
				end
				else
					next_state = H_IDLE;
			default:
				next_state = H_IDLE;
		endcase
	end

	// Link side, all on the link clock rising edge
	always_ff @(posedge link.link_clk or posedge link.bus_reset_in)
	begin
		if (link.bus_reset_in)
		begin
			cfg_meta <= HOST_CFG_RST;
			cfg_sync <= HOST_CFG_RST;
			state <= H_IDLE;
			cnt <= 8'h00;
			len <= 3'h0;
			mode_quiet <= 1'b0;
			first_pending <= 1'b1;
			oe_q <= 1'b0;
			out_q <= 1'b0;
			cap <= CAP_RST;
			pub <= HOST_IRQ_RST;
			pub_tgl <= 1'b0;
		end
		else
		begin
			cfg_meta <= {quiet_req, continuous_run, start_ext};
			cfg_sync <= cfg_meta;
			state <= next_state;
			cnt <= next_cnt;
			len <= next_len;
			oe_q <= next_oe;
			out_q <= next_out;
			if (next_state == H_START_LOW)
				first_pending <= 1'b0;
			if (stop_begin)
			begin
				mode_quiet <= cfg_quiet;
				pub <= cap[16:2];
				pub_tgl <= !pub_tgl;
			end
			if (cap_now)
				cap[cur_frame[4:0]] <= line;
		end
	end

	// User side: pick up each finished cycle and pace end-of-interrupt traffic
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
			tgl_seen <= 1'b0;
			irq_state <= HOST_IRQ_RST;
			update_pulse <= 1'b0;
			eoi_cnt <= 7'h00;
			eoi_busy <= 1'b0;
			eoi_grant <= 1'b0;
		end
		else
		begin
			tgl_meta <= pub_tgl;
			tgl_sync <= tgl_meta;
			tgl_seen <= tgl_sync;
			update_pulse <= tgl_sync != tgl_seen;
			if (tgl_sync != tgl_seen)
				irq_state <= pub;
			eoi_grant <= eoi_busy && (eoi_cnt == 7'h00);
			if (eoi_busy)
			begin
				if (eoi_cnt == 7'h00)
					eoi_busy <= 1'b0;
				else
					eoi_cnt <= eoi_cnt - 7'h01;
			end
			else if (eoi_req)
			begin
				eoi_busy <= 1'b1;
				eoi_cnt <= EOI_DELAY_CYCLES - 7'h01;
			end
		end
	end
endmodule : serial_irq_host
`default_nettype wire

// ### rtl/serial_irq_slave.sv
// Device (slave) end of the serial interrupt link
`timescale 1ns/100ps
`default_nettype none
module serial_irq_slave
	import serial_irq_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:1] irq_level,
	input wire logic system_mgmt_int_n,
	input wire logic smi_frame_en,
	output logic quiet_mode,
	output logic cycle_active,
	serial_irq_if.device link
);
	dev_state_t state;
	dev_state_t next_state;
	logic [16:0] in_meta;
	logic [16:0] in_sync;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [1:0] low_run;
	logic quiet;
	logic active;
	logic oe_q;
	logic out_q;
	logic [16:0] rep;
	logic quiet_meta;
	logic active_meta;

	wire line = link.serial_int_line;
	wire [16:0] raw_in = {system_mgmt_int_n, irq_level, smi_frame_en};

	// Frame 3 source select; frame n otherwise carries interrupt n-1
	wire smi_sel = in_sync[0] ? in_sync[16] : in_sync[2];
	wire [16:0] slot_val = {in_sync[15:3], smi_sel, in_sync[1], 2'b11};
	wire [31:0] slot_ext = {15'h7fff, slot_val};

	// Any level differing from what was last reported needs a cycle
	wire pending = |(slot_val[16:2] ^ rep[16:2]);
	wire stop_seen = (state == D_FRAMES) && line && (low_run >= STOP_QUIET_W);
	wire [7:0] cnt_inc = (cnt == 8'hff) ? cnt : cnt + 8'h01;

	// Phase decode of the clock about to be driven
	wire in_frames = next_state == D_FRAMES;
	wire [7:0] nframe = sample_frame(next_cnt);
	wire in_slot = (nframe >= FIRST_DEV_FRAME) && (nframe <= LAST_DEV_FRAME);
	wire slot_now = in_frames && is_sample(next_cnt) && in_slot;
	wire drive_low = slot_now && !slot_ext[nframe[4:0]];
	wire drive_high = in_frames && is_recov(next_cnt) && oe_q && !out_q;
	// Turn-around and all other clocks leave both terms clear
	wire next_oe = (next_state == D_KICK) || drive_low || drive_high;
	wire next_out = drive_high;

	// Line released while bus reset is held
	assign link.dev_oe = oe_q && !link.bus_reset_in;
	assign link.dev_out = out_q;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			D_IDLE:
				if (!line)
					next_state = D_START;
				else if (quiet && pending)
					next_state = D_KICK;
			D_KICK:
				next_state = D_START;
			D_START:
				if (line)
				begin
					next_state = D_FRAMES;
					next_cnt = 8'h01;
				end
			D_FRAMES:
				if (stop_seen)
					next_state = D_IDLE;
				else
					next_cnt = cnt_inc;
			default:
				next_state = D_IDLE;
		endcase
	end

	// Consecutive low clocks inside the frames, saturating
	wire [1:0] next_low_run = (state != D_FRAMES || line) ? 2'h0
		: ((low_run == RUN_MAX) ? low_run : low_run + 2'h1);
	wire next_quiet = stop_seen ? (low_run == STOP_QUIET_W) : quiet;

	// User levels into the link domain through two flip-flops
	always_ff @(posedge link.link_clk or posedge link.bus_reset_in)
	begin
		if (link.bus_reset_in)
		begin
			in_meta <= DEV_IN_RST;
			in_sync <= DEV_IN_RST;
		end
		else
		begin
			in_meta <= raw_in;
			in_sync <= in_meta;
		end
	end

	// Frame sequencer
	always_ff @(posedge link.link_clk or posedge link.bus_reset_in)
	begin
		if (link.bus_reset_in)
		begin
			state <= D_IDLE;
			cnt <= 8'h00;
			active <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			active <= next_state != D_IDLE;
		end
	end

	// Line driver, launched on the rising edge
	always_ff @(posedge link.link_clk or posedge link.bus_reset_in)
	begin
		if (link.bus_reset_in)
		begin
			oe_q <= 1'b0;
			out_q <= 1'b0;
		end
		else
		begin
			oe_q <= next_oe;
			out_q <= next_out;
		end
	end

	// Value last reported in each slot, for change detection
	always_ff @(posedge link.link_clk or posedge link.bus_reset_in)
	begin
		if (link.bus_reset_in)
			rep <= REP_RST;
		else if (slot_now)
			rep[nframe[4:0]] <= slot_ext[nframe[4:0]];
	end

	// Stop pulse width decode
	always_ff @(posedge link.link_clk or posedge link.bus_reset_in)
	begin
		if (link.bus_reset_in)
		begin
			low_run <= 2'h0;
			quiet <= 1'b0;
		end
		else
		begin
			low_run <= next_low_run;
			quiet <= next_quiet;
		end
	end

	// Mode status back to the user clock
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			quiet_meta <= 1'b0;
			quiet_mode <= 1'b0;
		end
		else
		begin
			quiet_meta <= quiet;
			quiet_mode <= quiet_meta;
		end
	end

	// Cycle status back to the user clock
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			active_meta <= 1'b0;
			cycle_active <= 1'b0;
		end
		else
		begin
			active_meta <= active;
			cycle_active <= active_meta;
		end
	end
endmodule : serial_irq_slave
`default_nettype wire

// ### shared/serial_irq_if.sv
// Shared serial interrupt line with both agents' drivers and a pull-up
`timescale 1ns/100ps
`default_nettype none
interface serial_irq_if;
	logic link_clk;
	logic bus_reset_in;
	logic dev_out;
	logic dev_oe;
	logic host_out;
	logic host_oe;
	logic serial_int_line;

	// Any agent driving low wins; otherwise the line is high
	assign serial_int_line = !((dev_oe && !dev_out) || (host_oe && !host_out));

	modport device (
		input link_clk,
		input bus_reset_in,
		input serial_int_line,
		output dev_out,
		output dev_oe
	);

	modport host (
		input link_clk,
		input bus_reset_in,
		input serial_int_line,
		output host_out,
		output host_oe
	);
endinterface : serial_irq_if
`default_nettype wire

// ### shared/serial_irq_pkg.sv
// Shared constants, types and frame decoding for the serial interrupt link
package serial_irq_pkg;

	// Frame structure
	localparam logic [7:0] FRAME_CLOCKS = 8'h03;
	localparam logic [7:0] FIRST_DEV_FRAME = 8'h02;
	localparam logic [7:0] LAST_DEV_FRAME = 8'h10;
	localparam logic [7:0] HOST_FRAMES = 8'h11;
	localparam logic [7:0] HOST_LAST_TA = 8'(FRAME_CLOCKS * HOST_FRAMES + 8'h01);

	// Stop pulse low widths and start pulse host extension
	localparam logic [1:0] STOP_QUIET_W = 2'h2;
	localparam logic [1:0] STOP_CONT_W = 2'h3;
	localparam logic [1:0] RUN_MAX = 2'h3;
	localparam logic [2:0] START_EXT_MIN = 3'h3;
	localparam logic [2:0] START_EXT_MAX = 3'h7;

	// Reset values
	localparam logic [16:0] DEV_IN_RST = 17'h1fffe;
	localparam logic [16:0] REP_RST = 17'h1ffff;
	localparam logic [16:0] CAP_RST = 17'h1ffff;
	localparam logic [15:1] HOST_IRQ_RST = 15'h7fff;
	localparam logic [4:0] HOST_CFG_RST = 5'h00;

	// Update latency and the delay it imposes on end-of-interrupt traffic
	localparam int LATENCY_CLOCKS = 96;
	localparam int LINK_PERIOD_NS = 32;
	localparam int CLK_PERIOD_NS = 50;
	localparam int EOI_DELAY_NS = LATENCY_CLOCKS * LINK_PERIOD_NS;
	localparam logic [6:0] EOI_DELAY_CYCLES =
		7'((EOI_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {D_IDLE, D_KICK, D_START, D_FRAMES} dev_state_t;
	typedef enum logic [2:0] {H_IDLE, H_START_LOW, H_START_HIGH, H_FRAMES,
		H_STOP_LOW, H_STOP_HIGH, H_STOP_TA} host_state_t;

	// Clock p after the start rising edge is a sample phase
	function automatic logic is_sample(input logic [7:0] p);
		return (p % FRAME_CLOCKS) == 8'h02;
	endfunction : is_sample

	// Clock p after the start rising edge is a recovery phase
	function automatic logic is_recov(input logic [7:0] p);
		return (p != 8'h00) && ((p % FRAME_CLOCKS) == 8'h00);
	endfunction : is_recov

	// Frame number whose sample phase is clock p
	function automatic logic [7:0] sample_frame(input logic [7:0] p);
		return 8'((p + 8'h01) / FRAME_CLOCKS);
	endfunction : sample_frame

endpackage : serial_irq_pkg

// ### tb/serial_irq_checker.sv
// Protocol checker watching the shared serial interrupt line
`timescale 1ns/100ps
`default_nettype none
module serial_irq_checker (
	input wire logic link_clk,
	input wire logic bus_reset_in,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic host_out,
	input wire logic host_oe,
	input wire logic serial_int_line
);
	logic [7:0] pos;
	logic [7:0] since;
	logic [3:0] run;
	logic quiet;
	wire logic dev_low = dev_oe && !dev_out;
	wire logic dev_high = dev_oe && dev_out;
	wire logic start_rise = serial_int_line && run > 4'h3;
	wire logic stop_rise = serial_int_line && (run == 4'h2 || run == 4'h3);
	wire logic kick = dev_low && pos > 8'h34;
	// Clocks since start rise, clocks since stop rise, low run length, latched mode
	always_ff @(posedge link_clk or posedge bus_reset_in)
	begin
		if (bus_reset_in)
		begin
			pos <= 8'hff;
			since <= 8'hff;
			run <= 4'h0;
			quiet <= 1'b0;
		end
		else
		begin
			pos <= start_rise ? 8'h01 : pos + {7'h00, pos != 8'hff};
			since <= stop_rise ? 8'h01 : since + {7'h00, since != 8'hff};
			run <= serial_int_line ? 4'h0 : run + {3'h0, run != 4'hf};
			quiet <= stop_rise ? run == 4'h2 : quiet;
		end
	end
	default clocking cb @(posedge link_clk);
	endclocking
	default disable iff (bus_reset_in);
	reset_release_a: assert property (disable iff (1'b0) bus_reset_in |-> !dev_oe && !host_oe)
		else $error("line driven during bus reset");
	kick_mode_a: assert property (kick |-> quiet)
		else $error("device started a cycle in continuous mode");
	kick_spacing_a: assert property (kick |-> since >= 8'h02)
		else $error("device start too close to stop");
	slot_timing_a: assert property (dev_low && pos <= 8'h34 |-> pos % 8'h03 == 8'h02 && pos >= 8'h05 && pos <= 8'h2f)
		else $error("device low outside a sample phase");
	recov_drive_a: assert property (dev_high |-> $past(dev_low))
		else $error("device drove high without a prior low");
	sample_recov_a: assert property (dev_low && pos <= 8'h34 |=> dev_high)
		else $error("no recovery high after sample low");
	turn_around_a: assert property (dev_high |=> !dev_oe)
		else $error("line not released in turn-around");
	kick_release_a: assert property (kick |=> !dev_oe)
		else $error("kick not one clock then release");
	no_stop_drive_a: assert property (pos >= 8'h31 && pos <= 8'h38 |-> !dev_oe)
		else $error("device drove during stop frame");
	start_width_a: assert property (start_rise |-> host_oe && host_out && run <= 4'h8)
		else $error("start pulse width or host high wrong");
	kick_seen_c: cover property (kick);
	quiet_stop_c: cover property (stop_rise && run == 4'h2);
	smi_slot_c: cover property (dev_low && pos == 8'h08);
endmodule : serial_irq_checker
`default_nettype wire

// ### tb/test_serial_irq_slave.sv
// Self-checking bench joining the device and host ends of the link
`timescale 1ns/100ps
`default_nettype none
module test_serial_irq_slave;
	import serial_irq_pkg::*;
	logic clk, reset_n, system_mgmt_int_n, smi_frame_en, quiet_req, continuous_run, eoi_req;
	logic quiet_mode, cycle_active, update_pulse, eoi_grant, seen;
	logic [15:1] irq_level;
	logic [15:1] irq_state;
	logic [2:0] start_ext;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	serial_irq_if serial_irq_if_i ();
	serial_irq_slave serial_irq_slave_i (.clk(clk), .reset_n(reset_n), .irq_level(irq_level),
		.system_mgmt_int_n(system_mgmt_int_n), .smi_frame_en(smi_frame_en),
		.quiet_mode(quiet_mode), .cycle_active(cycle_active), .link(serial_irq_if_i));
	serial_irq_host serial_irq_host_i (.clk(clk), .reset_n(reset_n), .quiet_req(quiet_req),
		.continuous_run(continuous_run), .start_ext(start_ext), .eoi_req(eoi_req),
		.irq_state(irq_state), .update_pulse(update_pulse), .eoi_grant(eoi_grant),
		.link(serial_irq_if_i));
	serial_irq_checker serial_irq_checker_i (.link_clk(serial_irq_if_i.link_clk),
		.bus_reset_in(serial_irq_if_i.bus_reset_in), .dev_out(serial_irq_if_i.dev_out),
		.dev_oe(serial_irq_if_i.dev_oe), .host_out(serial_irq_if_i.host_out),
		.host_oe(serial_irq_if_i.host_oe), .serial_int_line(serial_irq_if_i.serial_int_line));
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		serial_irq_if_i.link_clk = 1'h0;
		#7;
		forever #16 serial_irq_if_i.link_clk = ~serial_irq_if_i.link_clk;
	end
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			n_fail = n_fail + 1;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("Checks: %0d, mismatches: %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic check(input logic ok, input string what);
		total_checks = total_checks + 1;
		if (ok !== 1'h1)
		begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : check
	// Waits a bounded number of clocks for the host's update strobe
	task automatic wait_upd(input int limit);
		seen = 1'h0;
		repeat (limit)
		begin
			@(posedge clk);
			#1;
			if (update_pulse === 1'h1)
			begin
				seen = 1'h1;
				break;
			end
		end
	endtask : wait_upd
	function automatic logic [15:1] want();
		logic [15:1] e;
		e = irq_level;
		e[2] = smi_frame_en ? system_mgmt_int_n : irq_level[2];
		return e;
	endfunction : want
	task automatic t_first();
		wait_upd(400);
		check(seen && irq_state === want(), "first cycle levels");
		check(quiet_mode === 1'h0, "not continuous after reset");
	endtask : t_first
	task automatic t_cont();
		logic [15:1] pat [4] = '{15'h7fff, 15'h0000, 15'h5555, 15'h6aaa};
		@(negedge clk);
		continuous_run = 1'h1;
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk);
			irq_level = pat[i];
			smi_frame_en = i[0];
			system_mgmt_int_n = i[1];
			wait_upd(200);
			wait_upd(200);
			check(seen && irq_state === want(), "continuous levels");
		end
	endtask : t_cont
	task automatic t_quiet();
		@(negedge clk);
		quiet_req = 1'h1;
		wait_upd(200);
		wait_upd(200);
		@(negedge clk);
		continuous_run = 1'h0;
		wait_upd(200);
		repeat (100) @(posedge clk);
		check(quiet_mode === 1'h1 && cycle_active === 1'h0, "quiet not entered");
		for (int x = 3; x < 8; x++)
		begin
			@(negedge clk);
			start_ext = 3'(x);
			irq_level = irq_level ^ (15'h0001 << x);
			wait_upd(200);
			check(seen && irq_state === want(), "kick cycle levels");
			repeat (100) @(posedge clk);
		end
	endtask : t_quiet
	task automatic t_back();
		@(negedge clk);
		quiet_req = 1'h0;
		irq_level[1] = ~irq_level[1];
		wait_upd(200);
		check(seen && irq_state === want(), "last quiet cycle");
		repeat (100) @(posedge clk);
		check(quiet_mode === 1'h0, "continuous not restored");
		@(negedge clk);
		irq_level[15] = ~irq_level[15];
		wait_upd(300);
		check(!seen, "device started a cycle");
		@(negedge clk);
		continuous_run = 1'h1;
		wait_upd(200);
		wait_upd(200);
		check(seen && irq_state === want(), "levels after resume");
	endtask : t_back
	task automatic t_eoi();
		int n;
		n = 0;
		@(negedge clk);
		eoi_req = 1'h1;
		@(negedge clk);
		eoi_req = 1'h0;
		do
		begin
			@(posedge clk);
			#1;
			n = n + 1;
		end
		while (eoi_grant !== 1'h1 && n < 100);
		check(n == int'(EOI_DELAY_CYCLES), "end-of-interrupt delay");
		check(n * CLK_PERIOD_NS >= LATENCY_CLOCKS * LINK_PERIOD_NS, "grant ahead of latency");
		@(posedge clk);
		#1;
		check(eoi_grant === 1'h0, "grant longer than one clock");
	endtask : t_eoi
	initial
	begin
		reset_n = 1'h0;
		serial_irq_if_i.bus_reset_in = 1'h1;
		irq_level = 15'h5aa5;
		system_mgmt_int_n = 1'h0;
		smi_frame_en = 1'h1;
		quiet_req = 1'h0;
		continuous_run = 1'h0;
		start_ext = 3'h3;
		eoi_req = 1'h0;
		repeat (16) @(negedge clk);
		reset_n = 1'h1;
		serial_irq_if_i.bus_reset_in = 1'h0;
		t_first();
		t_cont();
		t_quiet();
		t_back();
		t_eoi();
		finish_test();
	end
endmodule : test_serial_irq_slave
`default_nettype wire
